// ===== design/pwmg_consts.vh
`ifndef PWMG_CONSTS_VH
`define PWMG_CONSTS_VH

// ************************************************
// global register offsets
// ************************************************
`define PWMG_OFF_CTL 8'h00
`define PWMG_OFF_SYNC 8'h04
`define PWMG_OFF_ENABLE 8'h08
`define PWMG_OFF_INVERT 8'h0c
`define PWMG_OFF_FAULT 8'h10
`define PWMG_OFF_INTEN 8'h14
`define PWMG_OFF_STATUS 8'h20

// ************************************************
// generator register offsets, base 0x40 * (n + 1)
// ************************************************
`define PWMG_GOFF_CTL 6'h00
`define PWMG_GOFF_INTEN 6'h04
`define PWMG_GOFF_LOAD 6'h10
`define PWMG_GOFF_COUNT 6'h14
`define PWMG_GOFF_CMPA 6'h18
`define PWMG_GOFF_CMPB 6'h1c
`define PWMG_GOFF_GENA 6'h20
`define PWMG_GOFF_GENB 6'h24
`define PWMG_GOFF_DBCTL 6'h28
`define PWMG_GOFF_DBRISE 6'h2c
`define PWMG_GOFF_DBFALL 6'h30

// ************************************************
// generator control fields and global fault interrupt enable bit
// ************************************************
`define PWMG_CTL_RUN 0
`define PWMG_CTL_UPDOWN 1
`define PWMG_CTL_DBGRUN 2
`define PWMG_CTL_SYNC_LOAD 3
`define PWMG_CTL_SYNC_CMPA 4
`define PWMG_CTL_SYNC_CMPB 5
`define PWMG_CTL_W 6
`define PWMG_FAULT_INTEN 0

// ************************************************
// event vector positions and action fields
// ************************************************
`define PWMG_EV_ZERO 0
`define PWMG_EV_LOAD 1
`define PWMG_EV_CAU 2
`define PWMG_EV_CAD 3
`define PWMG_EV_CBU 4
`define PWMG_EV_CBD 5
`define PWMG_EV_N 6
`define PWMG_TRIG_LSB 8
`define PWMG_ACT_W 12
`define PWMG_ACT_NONE 2'h0
`define PWMG_ACT_TOGGLE 2'h1
`define PWMG_ACT_LOW 2'h2
`define PWMG_ACT_HIGH 2'h3

`define PWMG_RST_VAL 32'h00000000

`endif

// ===== design/pwmg_deadband.v
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_consts.vh"

module pwmg_deadband #(
   parameter DB_W = 12
)
(
   // clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // control
   input wire i_en,
   input wire [DB_W-1:0] i_rise,
   input wire [DB_W-1:0] i_fall,
   // signals
   input wire i_pwm_a,
   input wire i_pwm_b,
   output reg o_out0,
   output reg o_out1
);

   reg [DB_W-1:0] rcnt_q;
   reg [DB_W-1:0] fcnt_q;

   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         rcnt_q <= {DB_W{1'b0}};
         fcnt_q <= {DB_W{1'b0}};
         o_out0 <= 1'b0;
         o_out1 <= 1'b0;
      end
      else if (!i_en)
      begin
         rcnt_q <= {DB_W{1'b0}};
         fcnt_q <= {DB_W{1'b0}};
         o_out0 <= i_pwm_a;
         o_out1 <= i_pwm_b;
      end
      else
      begin
         // rising edge of a delayed, falling edge immediate
         if (!i_pwm_a)
         begin
            rcnt_q <= {DB_W{1'b0}};
            o_out0 <= 1'b0;
         end
         else if (rcnt_q >= i_rise)
            o_out0 <= 1'b1;
         else
            rcnt_q <= rcnt_q + 1'b1;
         // inverse of a, rising only after fall delay
         if (i_pwm_a)
         begin
            fcnt_q <= {DB_W{1'b0}};
            o_out1 <= 1'b0;
         end
         else if (fcnt_q >= i_fall)
            o_out1 <= 1'b1;
         else
            fcnt_q <= fcnt_q + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ===== design/pwmg_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_consts.vh"

module pwmg_gen #(
   parameter CNT_W = 16
)
(
   // clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // control
   input wire i_run,
   input wire i_updown,
   input wire i_dbg_run,
   input wire i_stall,
   input wire i_cnt_rst,
   input wire i_gupd,
   input wire i_sync_load,
   input wire i_sync_cmpa,
   input wire i_sync_cmpb,
   // shadow values
   input wire [CNT_W-1:0] i_load,
   input wire [CNT_W-1:0] i_cmpa,
   input wire [CNT_W-1:0] i_cmpb,
   input wire [`PWMG_ACT_W-1:0] i_act_a,
   input wire [`PWMG_ACT_W-1:0] i_act_b,
   // status and events
   output wire [CNT_W-1:0] o_count,
   output wire o_dir,
   output wire [`PWMG_EV_N-1:0] o_evt,
   output wire o_pwm_a,
   output wire o_pwm_b
);

   reg [CNT_W-1:0] cnt_q;
   reg dir_q;
   reg [CNT_W-1:0] load_q;
   reg [CNT_W-1:0] cmpa_q;
   reg [CNT_W-1:0] cmpb_q;
   reg pend_q;
   reg a_q;
   reg b_q;
   reg a_d;
   reg b_d;
   wire go;
   wire zero;
   wire ld;
   wire ma;
   wire mb;
   wire mask;
   wire upd_load;
   wire [CNT_W-1:0] load_nx;

   function act;
      input cur;
      input [1:0] code;
      begin
         case (code)
            `PWMG_ACT_TOGGLE: act = ~cur;
            `PWMG_ACT_LOW: act = 1'b0;
            `PWMG_ACT_HIGH: act = 1'b1;
            default: act = cur;
         endcase
      end
   endfunction

   // ************************************************
   // counter and events
   // ************************************************
   assign go = i_run & ~(i_stall & ~i_dbg_run & (cnt_q == {CNT_W{1'b0}}));
   assign zero = go & (cnt_q == {CNT_W{1'b0}});
   assign ld = go & (cnt_q == load_q);
   assign ma = go & (cnt_q == cmpa_q) & (cmpa_q <= load_q);
   assign mb = go & (cnt_q == cmpb_q) & (cmpb_q <= load_q);
   assign o_evt[`PWMG_EV_ZERO] = zero;
   assign o_evt[`PWMG_EV_LOAD] = ld;
   assign o_evt[`PWMG_EV_CAU] = ma & dir_q;
   assign o_evt[`PWMG_EV_CAD] = ma & ~dir_q;
   assign o_evt[`PWMG_EV_CBU] = mb & dir_q;
   assign o_evt[`PWMG_EV_CBD] = mb & ~dir_q;
   assign mask = zero | ld;
   // reload uses the value taking effect at this zero
   assign upd_load = zero & (~i_sync_load | pend_q);
   assign load_nx = upd_load ? i_load : load_q;
   assign o_count = cnt_q;
   assign o_dir = dir_q;
   assign o_pwm_a = a_q;
   assign o_pwm_b = b_q;

   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst | i_cnt_rst)
      begin
         cnt_q <= {CNT_W{1'b0}};
         dir_q <= 1'b0;
      end
      else if (go)
      begin
         if (!i_updown)
         begin
            dir_q <= 1'b0;
            if (cnt_q == {CNT_W{1'b0}})
               cnt_q <= load_nx;
            else
               cnt_q <= cnt_q - 1'b1;
         end
         else if (dir_q)
         begin
            if (cnt_q >= load_q)
            begin
               dir_q <= 1'b0;
               cnt_q <= (cnt_q == {CNT_W{1'b0}}) ? cnt_q : cnt_q - 1'b1;
            end
            else
               cnt_q <= cnt_q + 1'b1;
         end
         else if (cnt_q == {CNT_W{1'b0}})
         begin
            dir_q <= 1'b1;
            cnt_q <= (load_nx == {CNT_W{1'b0}}) ? cnt_q : cnt_q + 1'b1;
         end
         else
            cnt_q <= cnt_q - 1'b1;
      end
   end

   // ************************************************
   // value update at zero
   // ************************************************
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         load_q <= {CNT_W{1'b0}};
         cmpa_q <= {CNT_W{1'b0}};
         cmpb_q <= {CNT_W{1'b0}};
         pend_q <= 1'b0;
      end
      else
      begin
         pend_q <= i_gupd | (pend_q & ~zero);
         if (upd_load)
            load_q <= i_load;
         if (zero & (~i_sync_cmpa | pend_q))
            cmpa_q <= i_cmpa;
         if (zero & (~i_sync_cmpb | pend_q))
            cmpb_q <= i_cmpb;
      end
   end

   // ************************************************
   // signal generator
   // ************************************************
   always @*
   begin
      a_d = a_q;
      b_d = b_q;
      if (zero)
      begin
         a_d = act(a_d, i_act_a[1:0]);
         b_d = act(b_d, i_act_b[1:0]);
      end
      if (ld)
      begin
         a_d = act(a_d, i_act_a[3:2]);
         b_d = act(b_d, i_act_b[3:2]);
      end
      if (!mask)
      begin
         if (o_evt[`PWMG_EV_CAU])
            a_d = act(a_d, i_act_a[5:4]);
         if (o_evt[`PWMG_EV_CAD])
            a_d = act(a_d, i_act_a[7:6]);
         if (o_evt[`PWMG_EV_CBU])
            b_d = act(b_d, i_act_b[9:8]);
         if (o_evt[`PWMG_EV_CBD])
            b_d = act(b_d, i_act_b[11:10]);
      end
   end

   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end
      else
      begin
         a_q <= a_d;
         b_q <= b_d;
      end
   end

endmodule
`default_nettype wire

// ===== design/pwmg_top.v
// Behaviour
// - down mode: load to zero, reload, repeat
// - up/down mode: zero to load to zero
// - direction low in down mode, tracks slope
// - one-cycle pulses at zero and load
// - down mode: load pulse right after zero
// - comparators A and B pulse on match
// - matches tagged by direction in up/down
// - match value above load never matches
// - down mode: four events drive outputs
// - up/down mode: six events drive outputs
// - matches ignored during zero or load
// - output A uses A matches, B uses B
// - per event action: none, toggle, low, high
// - dead-band disabled passes both outputs
// - dead-band: delayed A and delayed inverse A
// - selectable events raise interrupt or trigger
// - interrupts and triggers from raw events
// - global synchronous reset of chosen counters
// - immediate or global-synchronised update at zero
// - fault forces enabled-for-fault outputs inactive
// - stall: halt at zero or keep running
// - one enable register, per-output inversion
// - counter, load, compare are 16 bits
// - three generators, six outputs
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwmg_consts.vh"

module pwmg_top #(
   parameter NGEN = 3,
   parameter CNT_W = 16,
   parameter DB_W = 12
)
(
   // clock and reset
   input wire i_ref_clk,
   input wire i_sys_rst,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg o_pready,
   output reg [31:0] o_prdata,
   output reg o_pslverr,
   // external conditions
   input wire i_fault,
   input wire i_dbg_stall,
   // pwm pins
   output reg [2*NGEN-1:0] o_pwm,
   // interrupts and converter triggers
   output reg [NGEN-1:0] o_gen_int,
   output reg [NGEN-1:0] o_adc_trig,
   output reg o_fault_int
);

   // ************************************************
   // registers
   // ************************************************
   reg [NGEN-1:0] gupd_q;
   reg [NGEN-1:0] cnt_rst_q;
   reg [2*NGEN-1:0] enable_q;
   reg [2*NGEN-1:0] invert_q;
   reg [2*NGEN-1:0] fault_en_q;
   reg fault_int_en_q;
   reg [`PWMG_CTL_W-1:0] ctl_q [0:NGEN-1];
   reg [2*`PWMG_EV_N-1:0] inten_q [0:NGEN-1];
   reg [CNT_W-1:0] load_q [0:NGEN-1];
   reg [CNT_W-1:0] cmpa_q [0:NGEN-1];
   reg [CNT_W-1:0] cmpb_q [0:NGEN-1];
   reg [`PWMG_ACT_W-1:0] gena_q [0:NGEN-1];
   reg [`PWMG_ACT_W-1:0] genb_q [0:NGEN-1];
   reg dben_q [0:NGEN-1];
   reg [DB_W-1:0] dbrise_q [0:NGEN-1];
   reg [DB_W-1:0] dbfall_q [0:NGEN-1];

   wire [CNT_W*NGEN-1:0] count_w;
   wire [`PWMG_EV_N*NGEN-1:0] evt_w;
   wire [NGEN-1:0] pa_w;
   wire [NGEN-1:0] pb_w;
   wire [2*NGEN-1:0] db_w;

   // ************************************************
   // apb decode
   // ************************************************
   wire acc = i_psel & i_penable;
   wire wr = acc & o_pready & i_pwrite;
   wire [1:0] blk = i_paddr[7:6];
   wire [5:0] goff = i_paddr[5:0];
   wire [1:0] gi = blk - 2'h1;
   wire gsel = (blk != 2'h0) && ({30'h0, gi} < NGEN);
   reg [31:0] rd_d;
   reg err_d;
   integer k;

   always @*
   begin
      rd_d = `PWMG_RST_VAL;
      err_d = 1'b0;
      if (blk == 2'h0)
      begin
         case (i_paddr)
            `PWMG_OFF_CTL: rd_d = `PWMG_RST_VAL;
            `PWMG_OFF_SYNC: rd_d = `PWMG_RST_VAL;
            `PWMG_OFF_ENABLE: rd_d[2*NGEN-1:0] = enable_q;
            `PWMG_OFF_INVERT: rd_d[2*NGEN-1:0] = invert_q;
            `PWMG_OFF_FAULT: rd_d[2*NGEN-1:0] = fault_en_q;
            `PWMG_OFF_INTEN: rd_d[`PWMG_FAULT_INTEN] = fault_int_en_q;
            `PWMG_OFF_STATUS: rd_d[0] = i_fault;
            default: err_d = 1'b1;
         endcase
      end
      else if (gsel)
      begin
         case (goff)
            `PWMG_GOFF_CTL: rd_d[`PWMG_CTL_W-1:0] = ctl_q[gi];
            `PWMG_GOFF_INTEN: rd_d[2*`PWMG_EV_N+1:0] = {inten_q[gi][2*`PWMG_EV_N-1:`PWMG_EV_N], 2'h0,
                                                        inten_q[gi][`PWMG_EV_N-1:0]};
            `PWMG_GOFF_LOAD: rd_d[CNT_W-1:0] = load_q[gi];
            `PWMG_GOFF_COUNT: rd_d[CNT_W-1:0] = count_w[gi*CNT_W +: CNT_W];
            `PWMG_GOFF_CMPA: rd_d[CNT_W-1:0] = cmpa_q[gi];
            `PWMG_GOFF_CMPB: rd_d[CNT_W-1:0] = cmpb_q[gi];
            `PWMG_GOFF_GENA: rd_d[`PWMG_ACT_W-1:0] = gena_q[gi];
            `PWMG_GOFF_GENB: rd_d[`PWMG_ACT_W-1:0] = genb_q[gi];
            `PWMG_GOFF_DBCTL: rd_d[0] = dben_q[gi];
            `PWMG_GOFF_DBRISE: rd_d[DB_W-1:0] = dbrise_q[gi];
            `PWMG_GOFF_DBFALL: rd_d[DB_W-1:0] = dbfall_q[gi];
            default: err_d = 1'b1;
         endcase
      end
      else
         err_d = 1'b1;
   end

   // one wait state: answer latched in first access cycle
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_pready <= 1'b0;
         o_prdata <= `PWMG_RST_VAL;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= acc & ~o_pready;
         if (acc & ~o_pready)
         begin
            o_prdata <= i_pwrite ? `PWMG_RST_VAL : rd_d;
            o_pslverr <= err_d;
         end
      end
   end

   // ************************************************
   // register writes
   // ************************************************
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         gupd_q <= {NGEN{1'b0}};
         cnt_rst_q <= {NGEN{1'b0}};
         enable_q <= {2*NGEN{1'b0}};
         invert_q <= {2*NGEN{1'b0}};
         fault_en_q <= {2*NGEN{1'b0}};
         fault_int_en_q <= 1'b0;
         for (k = 0; k < NGEN; k = k + 1)
         begin
            ctl_q[k] <= {`PWMG_CTL_W{1'b0}};
            inten_q[k] <= {2*`PWMG_EV_N{1'b0}};
            load_q[k] <= {CNT_W{1'b0}};
            cmpa_q[k] <= {CNT_W{1'b0}};
            cmpb_q[k] <= {CNT_W{1'b0}};
            gena_q[k] <= {`PWMG_ACT_W{1'b0}};
            genb_q[k] <= {`PWMG_ACT_W{1'b0}};
            dben_q[k] <= 1'b0;
            dbrise_q[k] <= {DB_W{1'b0}};
            dbfall_q[k] <= {DB_W{1'b0}};
         end
      end
      else
      begin
         gupd_q <= {NGEN{1'b0}};
         cnt_rst_q <= {NGEN{1'b0}};
         if (wr && !err_d && blk == 2'h0)
         begin
            case (i_paddr)
               `PWMG_OFF_CTL: gupd_q <= i_pwdata[NGEN-1:0];
               `PWMG_OFF_SYNC: cnt_rst_q <= i_pwdata[NGEN-1:0];
               `PWMG_OFF_ENABLE: enable_q <= i_pwdata[2*NGEN-1:0];
               `PWMG_OFF_INVERT: invert_q <= i_pwdata[2*NGEN-1:0];
               `PWMG_OFF_FAULT: fault_en_q <= i_pwdata[2*NGEN-1:0];
               `PWMG_OFF_INTEN: fault_int_en_q <= i_pwdata[`PWMG_FAULT_INTEN];
               default: fault_int_en_q <= fault_int_en_q;
            endcase
         end
         else if (wr && !err_d)
         begin
            case (goff)
               `PWMG_GOFF_CTL: ctl_q[gi] <= i_pwdata[`PWMG_CTL_W-1:0];
               `PWMG_GOFF_INTEN: inten_q[gi] <= {i_pwdata[`PWMG_TRIG_LSB+`PWMG_EV_N-1:`PWMG_TRIG_LSB],
                                                 i_pwdata[`PWMG_EV_N-1:0]};
               `PWMG_GOFF_LOAD: load_q[gi] <= i_pwdata[CNT_W-1:0];
               `PWMG_GOFF_CMPA: cmpa_q[gi] <= i_pwdata[CNT_W-1:0];
               `PWMG_GOFF_CMPB: cmpb_q[gi] <= i_pwdata[CNT_W-1:0];
               `PWMG_GOFF_GENA: gena_q[gi] <= i_pwdata[`PWMG_ACT_W-1:0];
               `PWMG_GOFF_GENB: genb_q[gi] <= i_pwdata[`PWMG_ACT_W-1:0];
               `PWMG_GOFF_DBCTL: dben_q[gi] <= i_pwdata[0];
               `PWMG_GOFF_DBRISE: dbrise_q[gi] <= i_pwdata[DB_W-1:0];
               `PWMG_GOFF_DBFALL: dbfall_q[gi] <= i_pwdata[DB_W-1:0];
               default: dben_q[gi] <= dben_q[gi];
            endcase
         end
      end
   end

   // ************************************************
   // generators and dead-band
   // ************************************************
   genvar g;
   generate
      for (g = 0; g < NGEN; g = g + 1)
      begin : gen_blk
         pwmg_gen #(
            .CNT_W(CNT_W)
         ) u_gen (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_run(ctl_q[g][`PWMG_CTL_RUN]),
            .i_updown(ctl_q[g][`PWMG_CTL_UPDOWN]),
            .i_dbg_run(ctl_q[g][`PWMG_CTL_DBGRUN]),
            .i_stall(i_dbg_stall),
            .i_cnt_rst(cnt_rst_q[g]),
            .i_gupd(gupd_q[g]),
            .i_sync_load(ctl_q[g][`PWMG_CTL_SYNC_LOAD]),
            .i_sync_cmpa(ctl_q[g][`PWMG_CTL_SYNC_CMPA]),
            .i_sync_cmpb(ctl_q[g][`PWMG_CTL_SYNC_CMPB]),
            .i_load(load_q[g]),
            .i_cmpa(cmpa_q[g]),
            .i_cmpb(cmpb_q[g]),
            .i_act_a(gena_q[g]),
            .i_act_b(genb_q[g]),
            .o_count(count_w[g*CNT_W +: CNT_W]),
            .o_dir(),
            .o_evt(evt_w[g*`PWMG_EV_N +: `PWMG_EV_N]),
            .o_pwm_a(pa_w[g]),
            .o_pwm_b(pb_w[g])
         );

         pwmg_deadband #(
            .DB_W(DB_W)
         ) u_db (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_en(dben_q[g]),
            .i_rise(dbrise_q[g]),
            .i_fall(dbfall_q[g]),
            .i_pwm_a(pa_w[g]),
            .i_pwm_b(pb_w[g]),
            .o_out0(db_w[2*g]),
            .o_out1(db_w[2*g+1])
         );

         // raw events, untouched by dead-band delays
         always @(posedge i_ref_clk)
         begin
            if (i_sys_rst)
            begin
               o_gen_int[g] <= 1'b0;
               o_adc_trig[g] <= 1'b0;
            end
            else
            begin
               o_gen_int[g] <= |(evt_w[g*`PWMG_EV_N +: `PWMG_EV_N] &
                                 inten_q[g][`PWMG_EV_N-1:0]);
               o_adc_trig[g] <= |(evt_w[g*`PWMG_EV_N +: `PWMG_EV_N] &
                                  inten_q[g][2*`PWMG_EV_N-1:`PWMG_EV_N]);
            end
         end
      end
   endgenerate

   // ************************************************
   // output control
   // ************************************************
   always @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_pwm <= {2*NGEN{1'b0}};
         o_fault_int <= 1'b0;
      end
      else
      begin
         o_pwm <= (db_w & enable_q & ~(fault_en_q & {2*NGEN{i_fault}})) ^ invert_q;
         o_fault_int <= i_fault & fault_int_en_q;
      end
   end

endmodule
`default_nettype wire

// ===== tb/pwmg_drv.sv
`timescale 1ns/1ps
`default_nettype none
module pwmg_drv
(
   // clock
   input wire logic i_ref_clk,
   // gate drive from the block
   input wire logic [5:0] i_pwm,
   // trip request from the bench
   input wire logic i_trip,
   // fault pin back to the block
   output wire logic o_fault
);
   logic fault_q = 1'b0;
   // driver trips one cycle after request
   always @(posedge i_ref_clk)
   begin
      fault_q <= i_trip;
   end
   assign o_fault = fault_q;
endmodule
`default_nettype wire

// ===== tb/pwmg_props.sv
`timescale 1ns/1ps
`default_nettype none
module pwmg_props #(
   parameter int NGEN = 3
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // apb
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic o_pslverr,
   // conditions
   input wire logic i_fault,
   input wire logic i_dbg_stall,
   // outputs
   input wire logic [2*NGEN-1:0] o_pwm,
   input wire logic [NGEN-1:0] o_gen_int,
   input wire logic [NGEN-1:0] o_adc_trig,
   input wire logic o_fault_int
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_acc;
      i_psel && i_penable && !o_pready;
   endsequence
   property p_wait;
      s_acc |=> o_pready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("no answer after one wait state");
   property p_pulse;
      o_pready |=> !o_pready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready longer than one cycle");
   property p_err;
      o_pready && o_pslverr |-> o_prdata == 32'h0;
   endproperty
   a_err: assert property (p_err)
      else $error("error answer carries data");
   property p_hold;
      !i_psel |=> $stable(o_prdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved while idle");
   property p_fint;
      o_fault_int |-> $past(i_fault);
   endproperty
   a_fint: assert property (p_fint)
      else $error("fault interrupt without fault");
   property p_fint_rst;
      $past(i_sys_rst) |-> !o_fault_int;
   endproperty
   a_fint_rst: assert property (p_fint_rst)
      else $error("fault interrupt after reset");
   property p_idle;
      $past(i_sys_rst) |-> o_pwm == '0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("pins active after reset");
   property p_int_idle;
      $past(i_sys_rst) |-> o_gen_int == '0 && o_adc_trig == '0;
   endproperty
   a_int_idle: assert property (p_int_idle)
      else $error("event pulse after reset");
endmodule
`default_nettype wire

// ===== tb/pwmg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
$display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module pwmg_top_bench;
   logic i_ref_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic i_dbg_stall = 1'b0, trip = 1'b0, rerr;
   logic [7:0] i_paddr = 8'h00, c;
   logic [31:0] i_pwdata = 32'h0, rdat, o_prdata;
   logic o_pready, o_pslverr, i_fault, o_fault_int;
   logic [5:0] o_pwm;
   logic [2:0] o_gen_int, o_adc_trig;
   int n_mismatch = 0, check_count = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   pwmg_top i_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_fault(i_fault),
      .i_dbg_stall(i_dbg_stall), .o_pwm(o_pwm), .o_gen_int(o_gen_int),
      .o_adc_trig(o_adc_trig), .o_fault_int(o_fault_int));
   pwmg_drv i_drv (.i_ref_clk(i_ref_clk), .i_pwm(o_pwm), .i_trip(trip), .o_fault(i_fault));
   task tally_and_finish;
   begin
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   // apb transfer, waits for ready
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
   begin
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      k = 0;
      @(posedge i_ref_clk);
      while (o_pready !== 1'b1 && k < 20)
      begin
         @(posedge i_ref_clk);
         k++;
      end
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_ref_clk);
      if (k >= 20)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   endtask
   // wait for event pulse, c = edges waited
   task wev(input int g);
      int k;
   begin
      k = 0;
      @(posedge i_ref_clk);
      while (o_gen_int[g] !== 1'b1 && k < 100)
      begin
         @(posedge i_ref_clk);
         k++;
      end
      c = 8'(k + 1);
      if (k >= 100)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end
   endtask
   // count high cycles of one pin
   task ones(input int b, input int n);
   begin
      c = 8'h00;
      repeat (n)
      begin
         @(posedge i_ref_clk);
         c = c + 8'(o_pwm[b]);
      end
   end
   endtask
   initial
   begin
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_ref_clk);
      acc(1'b0, 8'h08, 32'h0);
      `CHK(rdat, 32'h0)
      acc(1'b1, 8'h08, 32'h3f);
      acc(1'b0, 8'h08, 32'h0);
      `CHK(rdat, 32'h3f)
      acc(1'b0, 8'h18, 32'h0);
      `CHK({rerr, rdat}, {1'b1, 32'h0})
      acc(1'b1, 8'h08, 32'h01);
      $display("test regs done");
      acc(1'b1, 8'h50, 32'h4);
      acc(1'b1, 8'h58, 32'h2);
      acc(1'b1, 8'h60, 32'h83);
      acc(1'b1, 8'h44, 32'h201);
      acc(1'b1, 8'h40, 32'h1);
      wev(0);
      wev(0);
      `CHK(c, 8'd5)
      @(posedge i_ref_clk);
      `CHK({o_adc_trig[0], o_gen_int[0]}, 2'b10)
      ones(0, 20);
      `CHK(c, 8'd12)
      acc(1'b1, 8'h0c, 32'h1);
      ones(0, 20);
      `CHK(c, 8'd8)
      acc(1'b1, 8'h0c, 32'h0);
      $display("test down done");
      acc(1'b1, 8'h10, 32'h1);
      acc(1'b1, 8'h14, 32'h1);
      trip <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      ones(0, 10);
      `CHK(c, 8'd0)
      `CHK(o_fault_int, 1'b1)
      trip <= 1'b0;
      acc(1'b1, 8'h10, 32'h0);
      $display("test fault done");
      acc(1'b1, 8'h60, 32'hb0);
      acc(1'b1, 8'h40, 32'h3);
      wev(0);
      wev(0);
      `CHK(c, 8'd8)
      ones(0, 16);
      `CHK(c, 8'd8)
      $display("test updown done");
      acc(1'b1, 8'h90, 32'h4);
      acc(1'b1, 8'h98, 32'h5);
      acc(1'b1, 8'ha0, 32'h40);
      acc(1'b1, 8'h08, 32'h05);
      acc(1'b1, 8'h80, 32'h1);
      ones(2, 30);
      `CHK(c, 8'd0)
      $display("test nomatch done");
      acc(1'b1, 8'h40, 32'h1);
      i_dbg_stall <= 1'b1;
      repeat (20) @(posedge i_ref_clk);
      c = 8'h00;
      repeat (20)
      begin
         @(posedge i_ref_clk);
         c = c + 8'(o_gen_int[0]);
      end
      `CHK(c, 8'd0)
      acc(1'b0, 8'h54, 32'h0);
      `CHK(rdat, 32'h0)
      i_dbg_stall <= 1'b0;
      wev(0);
      $display("test stall done");
      acc(1'b1, 8'h60, 32'h83);
      acc(1'b1, 8'h08, 32'h03);
      acc(1'b1, 8'h6c, 32'h1);
      acc(1'b1, 8'h70, 32'h1);
      acc(1'b1, 8'h68, 32'h1);
      repeat (5) @(posedge i_ref_clk);
      ones(0, 20);
      `CHK(c, 8'd8)
      ones(1, 20);
      `CHK(c, 8'd4)
      $display("test deadband done");
      tally_and_finish;
   end
endmodule
bind pwmg_top pwmg_props #(.NGEN(NGEN)) i_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
   .i_fault(i_fault), .i_dbg_stall(i_dbg_stall), .o_pwm(o_pwm), .o_gen_int(o_gen_int),
   .o_adc_trig(o_adc_trig), .o_fault_int(o_fault_int));
`default_nettype wire
